//--- design/frp_cmd.sv
`timescale 1ns/10ps
// Summary of operation
// - resume 7Ah accepted only with suspend flag set and busy clear
// - accepted resume clears suspend flag at once, busy rises within 200ns
// - resume ignored when suspend flag clear or busy set
// - power loss (reset) clears suspend state so later resume is ignored
// - power-down B9h runs only if chip select rises right after eighth bit
// - after valid power-down, low-power state entered within entry delay
// - in low-power state only ABh is recognised, all else ignored
// - device comes out of power-up in normal operation
// - ABh then chip select high leaves low-power after plain release delay
// - ABh plus 3 dummy bytes returns device ID MSB first, repeating
// - release/device ID command ignored while erase/program/write busy
// - 90h plus zero 24-bit address returns maker then device ID serially
// - 92h takes address two bits per clock, returns IDs two bits per clock
// - 94h: four dummy clocks, address four bits per clock, IDs four wide
// - dual and quad ID reads use 32-bit address in four-byte mode
// - 4Bh plus four dummy bytes returns 64-bit unique number
// - accepted suspend 75h sets suspend flag at once, engine drops busy
module frp_cmd #(
   parameter logic [7:0]  MFR_ID             = 8'hA5,            // arbitrary value
   parameter logic [7:0]  DEVICE_ID          = 8'h3C,            // arbitrary value
   parameter logic [63:0] UNIQUE_ID          = 64'h0123456789ABCDEF, // arbitrary value
   parameter int          LOWPOWER_ENTRY_NS  = 3000,
   parameter int          RELEASE_PLAIN_NS   = 3000,
   parameter int          RELEASE_WITH_ID_NS = 1800,
   parameter int          TMR_W              = 16
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        cs_n_i,
   input  wire logic                        sclk_i,
   input  wire logic [3:0]                  io_i,
   output      logic [3:0]                  io_o,
   output      logic [3:0]                  io_oe_o,
   input  wire logic                        quad_peripheral_mode_i,
   input  wire logic                        four_byte_mode_i,
   input  wire logic                        array_busy_i,
   input  wire logic                        suspendable_i,
   output      frp_pkg::frp_status_type     status_o,
   output      frp_pkg::frp_engine_req_type engine_req_o
);
   // delays rounded down to whole cycles (maximum figures)
   localparam int ENTRY_CYC  = LOWPOWER_ENTRY_NS / frp_pkg::CLK_PERIOD_NS;
   localparam int REL1_CYC   = RELEASE_PLAIN_NS / frp_pkg::CLK_PERIOD_NS;
   localparam int REL2_CYC   = RELEASE_WITH_ID_NS / frp_pkg::CLK_PERIOD_NS;
   localparam logic [TMR_W-1:0] ENTRY_LOAD = TMR_W'(ENTRY_CYC - 1);
   localparam logic [TMR_W-1:0] REL1_LOAD  = TMR_W'(REL1_CYC - 1);
   localparam logic [TMR_W-1:0] REL2_LOAD  = TMR_W'(REL2_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO   = '0;

   logic [1:0]                 cs_sync_q;
   logic [1:0]                 sclk_sync_q;
   logic [3:0]                 io_sync1_q;
   logic [3:0]                 io_sync2_q;
   logic                       sclk_prev_q;
   logic                       cs_prev_q;
   logic                       cs_low;
   logic                       rise;
   logic                       fall;
   logic                       cs_rise;
   logic [7:0]                 clk_cnt_q;
   logic [7:0]                 op_sr_q;
   logic [7:0]                 op_next;
   logic [7:0]                 op_clks;
   logic                       op_done;
   logic [7:0]                 op_q;
   logic                       op_ok_q;
   logic                       op_ok_d;
   logic [7:0]                 data_start;
   logic [2:0]                 lanes;
   logic [63:0]                pattern;
   logic [63:0]                out_sr_q;
   logic                       data_phase;
   logic                       exact_op;
   frp_pkg::frp_pstate_type    pstate_q;
   logic [TMR_W-1:0]           tmr_q;
   logic                       suspend_flag_q;
   logic                       resume_pend_q;
   logic                       busy_flag;
   logic                       do_suspend;
   logic                       do_resume;
   logic                       do_lowpower;
   logic                       do_release;
   logic                       release_with_id;

   // two-stage synchronisers for the pins
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cs_sync_q   <= 2'h3;
         sclk_sync_q <= 2'h0;
         io_sync1_q  <= 4'h0;
         io_sync2_q  <= 4'h0;
      end else begin
         cs_sync_q   <= {cs_sync_q[0], cs_n_i};
         sclk_sync_q <= {sclk_sync_q[0], sclk_i};
         io_sync1_q  <= io_i;
         io_sync2_q  <= io_sync1_q;
      end
   end

   // edge detection on the synchronised pins
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_sync_q[1];
         cs_prev_q   <= cs_sync_q[1];
      end
   end

   assign cs_low  = ~cs_sync_q[1];
   assign rise    = cs_low & sclk_sync_q[1] & ~sclk_prev_q;
   assign fall    = cs_low & ~sclk_sync_q[1] & sclk_prev_q;
   assign cs_rise = cs_sync_q[1] & ~cs_prev_q;

   // opcode width: quad peripheral mode moves a nibble per clock
   assign op_clks = quad_peripheral_mode_i ? frp_pkg::CLK_OP_QPI : frp_pkg::CLK_OP_SPI;
   assign op_next = quad_peripheral_mode_i ? {op_sr_q[3:0], io_sync2_q} :
                                             {op_sr_q[6:0], io_sync2_q[0]};
   assign op_done = rise & (clk_cnt_q == op_clks - 8'h01);

   // serial clock count within the frame
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_cnt_q <= 8'h00;
      end else if (!cs_low) begin
         clk_cnt_q <= 8'h00;
      end else if (rise && clk_cnt_q != frp_pkg::CLK_MAX) begin
         clk_cnt_q <= clk_cnt_q + 8'h01;
      end
   end

   // opcode shift register
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_sr_q <= 8'h00;
      end else if (rise && clk_cnt_q < op_clks) begin
         op_sr_q <= op_next;
      end
   end

   // which opcodes the current power state lets through
   always_comb begin
      op_ok_d = 1'b0;
      case (pstate_q)
         frp_pkg::PS_NORMAL: begin
            op_ok_d = (op_next == frp_pkg::OP_RELEASE) ? ~busy_flag : 1'b1;
         end
         frp_pkg::PS_LOWPOWER: begin
            op_ok_d = (op_next == frp_pkg::OP_RELEASE);
         end
         default: begin
            op_ok_d = 1'b0;
         end
      endcase
   end

   // latched opcode and its permission
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_q    <= 8'h00;
         op_ok_q <= 1'b0;
      end else if (!cs_low) begin
         op_ok_q <= 1'b0;
      end else if (op_done) begin
         op_q    <= op_next;
         op_ok_q <= op_ok_d;
      end
   end

   // answer layout per identification command
   always_comb begin
      data_start = frp_pkg::CLK_MAX;
      lanes      = frp_pkg::W_SINGLE;
      pattern    = UNIQUE_ID;
      case (op_q)
         frp_pkg::OP_RELEASE: begin
            data_start = op_clks + (quad_peripheral_mode_i ? frp_pkg::CLK_AB_DUMMY_QPI
                                                           : frp_pkg::CLK_AB_DUMMY_SPI);
            lanes      = quad_peripheral_mode_i ? frp_pkg::W_QUAD : frp_pkg::W_SINGLE;
            pattern    = {8{DEVICE_ID}};
         end
         frp_pkg::OP_MFR_DEV: begin
            data_start = frp_pkg::CLK_90_START;
            pattern    = {4{MFR_ID, DEVICE_ID}};
         end
         frp_pkg::OP_MFR_DUAL: begin
            data_start = frp_pkg::CLK_OP_SPI + frp_pkg::CLK_92_MODE +
                         (four_byte_mode_i ? frp_pkg::CLK_92_ADDR4 : frp_pkg::CLK_92_ADDR3);
            lanes      = frp_pkg::W_DUAL;
            pattern    = {4{MFR_ID, DEVICE_ID}};
         end
         frp_pkg::OP_MFR_QUAD: begin
            data_start = frp_pkg::CLK_OP_SPI + frp_pkg::CLK_94_DUMMY + frp_pkg::CLK_94_MODE +
                         (four_byte_mode_i ? frp_pkg::CLK_94_ADDR4 : frp_pkg::CLK_94_ADDR3);
            lanes      = frp_pkg::W_QUAD;
            pattern    = {4{MFR_ID, DEVICE_ID}};
         end
         frp_pkg::OP_UNIQUE: begin
            data_start = frp_pkg::CLK_4B_START;
            pattern    = UNIQUE_ID;
         end
         default: begin
            data_start = frp_pkg::CLK_MAX;
         end
      endcase
   end

   // ID reads are spi-only except the release/device ID form
   assign data_phase = op_ok_q & (clk_cnt_q >= data_start) &
                       (~quad_peripheral_mode_i | (op_q == frp_pkg::OP_RELEASE));

   // answer shifter: loaded on the first rising clock edge after the opcode, rotated on falling clock edges
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_sr_q <= 64'h0;
      end else if (rise && clk_cnt_q == op_clks) begin
         out_sr_q <= pattern;
      end else if (fall && data_phase) begin
         case (lanes)
            frp_pkg::W_DUAL: out_sr_q <= {out_sr_q[61:0], out_sr_q[63:62]};
            frp_pkg::W_QUAD: out_sr_q <= {out_sr_q[59:0], out_sr_q[63:60]};
            default:         out_sr_q <= {out_sr_q[62:0], out_sr_q[63]};
         endcase
      end
   end

   // output pins, MSB first, changed on falling clock edges
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_o    <= 4'h0;
         io_oe_o <= 4'h0;
      end else if (!cs_low) begin
         io_oe_o <= 4'h0;
      end else if (fall && data_phase) begin
         case (lanes)
            frp_pkg::W_DUAL: begin
               io_o    <= {2'h0, out_sr_q[63:62]};
               io_oe_o <= 4'h3;
            end
            frp_pkg::W_QUAD: begin
               io_o    <= out_sr_q[63:60];
               io_oe_o <= 4'hF;
            end
            default: begin
               io_o    <= {2'h0, out_sr_q[63], 1'b0};
               io_oe_o <= 4'h2;
            end
         endcase
      end
   end

   // frame-end actions; write-type opcodes need chip select right after the opcode
   assign exact_op        = cs_rise & op_ok_q & (clk_cnt_q == op_clks);
   assign do_suspend      = exact_op & (op_q == frp_pkg::OP_SUSPEND) & ~suspend_flag_q &
                            array_busy_i & suspendable_i;
   assign do_resume       = exact_op & (op_q == frp_pkg::OP_RESUME) & suspend_flag_q &
                            ~busy_flag;
   assign do_lowpower     = exact_op & (op_q == frp_pkg::OP_LOWPOWER) & (pstate_q == frp_pkg::PS_NORMAL);
   assign release_with_id = cs_rise & op_ok_q & (op_q == frp_pkg::OP_RELEASE) &
                            (clk_cnt_q >= data_start);
   assign do_release      = (pstate_q == frp_pkg::PS_LOWPOWER) &
                            ((exact_op & (op_q == frp_pkg::OP_RELEASE)) | release_with_id);

   // power state machine with delay timer
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pstate_q <= frp_pkg::PS_NORMAL;
         tmr_q    <= TMR_ZERO;
      end else begin
         case (pstate_q)
            frp_pkg::PS_NORMAL: begin
               if (do_lowpower) begin
                  pstate_q <= frp_pkg::PS_ENTERING;
                  tmr_q    <= ENTRY_LOAD;
               end
            end
            frp_pkg::PS_ENTERING: begin
               if (tmr_q == TMR_ZERO) begin
                  pstate_q <= frp_pkg::PS_LOWPOWER;
               end else begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end
            end
            frp_pkg::PS_LOWPOWER: begin
               if (do_release) begin
                  pstate_q <= frp_pkg::PS_RELEASING;
                  tmr_q    <= release_with_id ? REL2_LOAD : REL1_LOAD;
               end
            end
            frp_pkg::PS_RELEASING: begin
               if (tmr_q == TMR_ZERO) begin
                  pstate_q <= frp_pkg::PS_NORMAL;
               end else begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end
            end
            default: begin
               pstate_q <= frp_pkg::PS_NORMAL;
               tmr_q    <= TMR_ZERO;
            end
         endcase
      end
   end

   // suspend flag; reset stands for power loss and drops it
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         suspend_flag_q <= 1'b0;
      end else if (do_suspend) begin
         suspend_flag_q <= 1'b1;
      end else if (do_resume) begin
         suspend_flag_q <= 1'b0;
      end
   end

   // busy held high from resume until the engine shows busy itself
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         resume_pend_q <= 1'b0;
      end else if (do_resume) begin
         resume_pend_q <= 1'b1;
      end else if (resume_pend_q && array_busy_i) begin
         resume_pend_q <= 1'b0;
      end
   end

   // one-cycle requests to the erase/program engine
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         engine_req_o <= '0;
      end else begin
         engine_req_o.suspend_req <= do_suspend;
         engine_req_o.resume_req  <= do_resume;
      end
   end

   assign busy_flag = array_busy_i | resume_pend_q;

   // status towards the rest of the device
   assign status_o.suspend_flag = suspend_flag_q;
   assign status_o.busy_flag    = busy_flag;
   assign status_o.lowpower     = (pstate_q == frp_pkg::PS_LOWPOWER);
endmodule

//--- design/frp_pkg.sv
package frp_pkg;
   // opcodes decoded by the block
   localparam logic [7:0] OP_SUSPEND   = 8'h75;
   localparam logic [7:0] OP_RESUME    = 8'h7A;
   localparam logic [7:0] OP_LOWPOWER  = 8'hB9;
   localparam logic [7:0] OP_RELEASE   = 8'hAB;
   localparam logic [7:0] OP_MFR_DEV   = 8'h90;
   localparam logic [7:0] OP_MFR_DUAL  = 8'h92;
   localparam logic [7:0] OP_MFR_QUAD  = 8'h94;
   localparam logic [7:0] OP_UNIQUE    = 8'h4B;

   // clock rate and delays
   localparam int CLK_PERIOD_NS        = 4;
   localparam int RESUME_BUSY_NS       = 200;
   localparam int RESUME_BUSY_CYC      = RESUME_BUSY_NS / CLK_PERIOD_NS;

   // serial-clock counts (rising edges since chip select fell)
   localparam logic [7:0] CLK_OP_SPI   = 8'h08;
   localparam logic [7:0] CLK_OP_QPI   = 8'h02;
   localparam logic [7:0] CLK_AB_DUMMY_SPI = 8'h18;
   localparam logic [7:0] CLK_AB_DUMMY_QPI = 8'h06;
   localparam logic [7:0] CLK_90_START = 8'h20;
   localparam logic [7:0] CLK_92_ADDR3 = 8'h0C;
   localparam logic [7:0] CLK_92_ADDR4 = 8'h10;
   localparam logic [7:0] CLK_92_MODE  = 8'h04;
   localparam logic [7:0] CLK_94_DUMMY = 8'h04;
   localparam logic [7:0] CLK_94_ADDR3 = 8'h06;
   localparam logic [7:0] CLK_94_ADDR4 = 8'h08;
   localparam logic [7:0] CLK_94_MODE  = 8'h02;
   localparam logic [7:0] CLK_4B_START = 8'h28;
   localparam logic [7:0] CLK_MAX      = 8'hFF;

   // lane widths of the answer
   localparam logic [2:0] W_SINGLE     = 3'h1;
   localparam logic [2:0] W_DUAL       = 3'h2;
   localparam logic [2:0] W_QUAD       = 3'h4;

   // power states
   typedef enum logic [3:0] {
      PS_NORMAL    = 4'h1,
      PS_ENTERING  = 4'h2,
      PS_LOWPOWER  = 4'h4,
      PS_RELEASING = 4'h8
   } frp_pstate_type;

   // status seen by the rest of the device
   typedef struct packed {
      logic suspend_flag;
      logic busy_flag;
      logic lowpower;
   } frp_status_type;

   // requests to the erase/program engine
   typedef struct packed {
      logic suspend_req;
      logic resume_req;
   } frp_engine_req_type;
endpackage

//--- verification/frp_cmd_sva.sv
`timescale 1ns/10ps
module frp_cmd_sva #(
   parameter int LOWPOWER_ENTRY_NS = 3000
) (
   input wire logic                        ref_clk_i,
   input wire logic                        rst_i,
   input wire logic                        cs_n_i,
   input wire logic [3:0]                  io_oe_o,
   input wire logic                        array_busy_i,
   input wire logic                        suspendable_i,
   input wire frp_pkg::frp_status_type     status_o,
   input wire frp_pkg::frp_engine_req_type engine_req_o
);
   localparam int ENTRY_CYC = LOWPOWER_ENTRY_NS / frp_pkg::CLK_PERIOD_NS;
   logic [15:0] hi_cnt_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // cycles that chip select has stayed high, saturating
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) hi_cnt_q <= 16'h0;
      else if (!cs_n_i) hi_cnt_q <= 16'h0;
      else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h1;
   end
   reset_quiet_a: assert property ($fell(rst_i) |-> io_oe_o == 4'h0 && !status_o.suspend_flag &&
      !status_o.lowpower && engine_req_o == 2'b00) else $error("state not clean after reset");
   resume_pulse_a: assert property ($fell(status_o.suspend_flag) |-> status_o.busy_flag &&
      engine_req_o.resume_req) else $error("resume did not raise busy and request");
   resume_guard_a: assert property (engine_req_o.resume_req |-> $past(status_o.suspend_flag) &&
      !$past(status_o.busy_flag)) else $error("resume accepted in wrong state");
   resume_busy_a: assert property (engine_req_o.resume_req |-> status_o.busy_flag)
      else $error("busy low at resume request");
   suspend_pulse_a: assert property ($rose(status_o.suspend_flag) |-> $past(array_busy_i) &&
      $past(suspendable_i) && engine_req_o.suspend_req) else $error("suspend flag without request");
   lowpower_noreq_a: assert property (status_o.lowpower |-> engine_req_o == 2'b00)
      else $error("engine request while in low power");
   entry_delay_a: assert property ($rose(status_o.lowpower) |-> hi_cnt_q <= ENTRY_CYC + 8)
      else $error("low power entered late");
   idle_release_a: assert property (hi_cnt_q >= 16'h8 |-> io_oe_o == 4'h0)
      else $error("lanes driven with chip select high");
endmodule
bind frp_cmd frp_cmd_sva #(.LOWPOWER_ENTRY_NS(LOWPOWER_ENTRY_NS)) i_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .cs_n_i(cs_n_i), .io_oe_o(io_oe_o), .array_busy_i(array_busy_i), .suspendable_i(suspendable_i),
   .status_o(status_o), .engine_req_o(engine_req_o));

//--- verification/frp_host.sv
`timescale 1ns/10ps
module frp_host (
   input  wire logic       ref_clk_i,
   input  wire logic [3:0] io_i,
   output      logic       cs_n_o,
   output      logic       sclk_o,
   output      logic [3:0] io_o,
   output      logic [3:0] io_oe_o
);
   // idle bus: select high, clock parked low, lanes released
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      io_o = 4'h0;
      io_oe_o = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // one serial clock, lanes set up half a period before the rise
   task automatic pulse(input logic [3:0] v, input logic [3:0] oe);
      io_o = v;
      io_oe_o = oe;
      tick(20);
      sclk_o = 1'b1;
      tick(20);
      sclk_o = 1'b0;
   endtask
   task automatic start();
      tick(1);
      cs_n_o = 1'b0;
      tick(10);
   endtask
   // constant pattern: zero address, dummies, mode nibbles
   task automatic fill(input logic [3:0] v, input int n, input logic [3:0] oe);
      repeat (n) pulse(v, oe);
   endtask
   task automatic op(input logic [7:0] code, input logic quad);
      if (quad) begin
         pulse(code[7:4], 4'hF);
         pulse(code[3:0], 4'hF);
      end else begin
         for (int i = 7; i >= 0; i--) begin
            pulse({3'h0, code[i]}, 4'h1);
         end
      end
   endtask
   // answer lanes sampled just before each rise, msb first
   task automatic rd(input int n, input int w, output logic [63:0] d);
      d = 64'h0;
      io_oe_o = 4'h0;
      repeat (n) begin
         tick(20);
         if (w == 1) d = {d[62:0], io_i[1]};
         else if (w == 2) d = {d[61:0], io_i[1:0]};
         else d = {d[59:0], io_i};
         sclk_o = 1'b1;
         tick(20);
         sclk_o = 1'b0;
      end
   endtask
   // select rises right after the last fall, then stays high
   task automatic stop(input int rest);
      tick(2);
      cs_n_o = 1'b1;
      io_oe_o = 4'h0;
      tick(rest);
   endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam logic [7:0]  MFR = 8'h5A;                 // arbitrary value
   localparam logic [7:0]  DEV = 8'hC3;                 // arbitrary value
   localparam logic [63:0] UID = 64'hFEDCBA9876543210;  // arbitrary value
   logic                        ref_clk_i = 1'b0;
   logic                        rst_i = 1'b1;
   logic                        quad = 1'b0;
   logic                        fourb = 1'b0;
   logic                        abusy = 1'b0;
   logic                        susp_ok = 1'b0;
   logic                        junk = 1'b0;
   logic                        cs_n;
   logic                        sclk;
   logic [3:0]                  h_o;
   logic [3:0]                  h_oe;
   logic [3:0]                  d_o;
   logic [3:0]                  d_oe;
   logic [3:0]                  io_w;
   logic [63:0]                 v;
   frp_pkg::frp_status_type     st;
   frp_pkg::frp_engine_req_type req;
   int                          errors = 0;
   int                          n_compared = 0;
   int                          cyc = 0;
   int                          n_res = 0;
   int                          n_sus = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   // a released lane toggles every cycle so stale bits never pass
   always @(posedge ref_clk_i) junk <= ~junk;
   assign io_w = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & {4{junk}});
   frp_host i_host (.ref_clk_i(ref_clk_i), .io_i(io_w), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(h_o), .io_oe_o(h_oe));
   frp_cmd #(.MFR_ID(MFR), .DEVICE_ID(DEV), .UNIQUE_ID(UID)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .cs_n_i(cs_n), .sclk_i(sclk),
      .io_i(io_w), .io_o(d_o), .io_oe_o(d_oe), .quad_peripheral_mode_i(quad), .four_byte_mode_i(fourb),
      .array_busy_i(abusy), .suspendable_i(susp_ok), .status_o(st), .engine_req_o(req));
   // request pulse counters and hang guard
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (req.resume_req === 1'b1) n_res <= n_res + 1;
      if (req.suspend_req === 1'b1) n_sus <= n_sus + 1;
      if (cyc == 60000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // full identification frame: opcode, dummies, zero address, mode byte for dual and quad, answer
   task automatic id_read(input logic [7:0] code, input int pre, input int adr, input int w, input int nrd,
                          input logic [3:0] eoe, output logic [63:0] d);
      logic [3:0] oe;
      int         m;
      oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
      m = (w == 4) ? 1 : (w == 2) ? 2 : 0;
      i_host.start();
      i_host.op(code, 1'b0);
      i_host.fill(4'h0, pre + adr, oe);
      i_host.fill(oe, m, oe);
      i_host.fill(4'h0, m, oe);
      i_host.rd(nrd, w, d);
      chk("lanes", d_oe, eoe);
      i_host.stop(40);
   endtask
   task automatic cmd(input logic [7:0] code, input logic q, input int extra);
      i_host.start();
      i_host.op(code, q);
      i_host.fill(4'h0, extra, q ? 4'hF : 4'h1);
      i_host.stop(40);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      i_host.tick(4);
      chk("lowpower", st.lowpower, 1'b0);
      chk("suspend", st.suspend_flag, 1'b0);
      id_read(frp_pkg::OP_MFR_DEV, 0, 24, 1, 24, 4'h2, v);
      chk("id 90h", v[23:0], {MFR, DEV, MFR});
      for (int fb = 0; fb < 2; fb++) begin
         fourb = fb[0];
         id_read(frp_pkg::OP_MFR_DUAL, 0, fb ? 16 : 12, 2, 16, 4'h3, v);
         chk("id 92h", v[31:0], {MFR, DEV, MFR, DEV});
         id_read(frp_pkg::OP_MFR_QUAD, 4, fb ? 8 : 6, 4, 8, 4'hF, v);
         chk("id 94h", v[31:0], {MFR, DEV, MFR, DEV});
      end
      fourb = 1'b0;
      id_read(frp_pkg::OP_UNIQUE, 32, 0, 1, 64, 4'h2, v);
      chk("unique", v, UID);
      id_read(frp_pkg::OP_RELEASE, 24, 0, 1, 16, 4'h2, v);
      chk("id abh", v[15:0], {DEV, DEV});
      abusy = 1'b1;
      id_read(frp_pkg::OP_RELEASE, 24, 0, 1, 8, 4'h0, v);
      // running operation not suspendable: suspend refused
      cmd(frp_pkg::OP_SUSPEND, 1'b0, 0);
      chk("suspend refused", st.suspend_flag, 1'b0);
      susp_ok = 1'b1;
      cmd(frp_pkg::OP_SUSPEND, 1'b0, 0);
      chk("suspend set", st.suspend_flag, 1'b1);
      chk("suspend req", n_sus, 1);
      cmd(frp_pkg::OP_RESUME, 1'b0, 0);
      chk("resume busy", st.suspend_flag, 1'b1);
      abusy = 1'b0;
      cmd(frp_pkg::OP_RESUME, 1'b0, 0);
      chk("resume flag", st.suspend_flag, 1'b0);
      chk("resume busy", st.busy_flag, 1'b1);
      chk("resume req", n_res, 1);
      abusy = 1'b1;
      i_host.tick(200);
      cmd(frp_pkg::OP_SUSPEND, 1'b0, 0);
      chk("suspend again", st.suspend_flag, 1'b1);
      rst_i = 1'b1;
      abusy = 1'b0;
      i_host.tick(2);
      rst_i = 1'b0;
      i_host.tick(4);
      cmd(frp_pkg::OP_RESUME, 1'b0, 0);
      chk("resume lost", n_res, 1);
      // waits outlast the entry delay, so a wrong entry would show
      cmd(frp_pkg::OP_LOWPOWER, 1'b0, 1);
      i_host.tick(800);
      chk("lowpower long", st.lowpower, 1'b0);
      cmd(frp_pkg::OP_LOWPOWER, 1'b0, 0);
      i_host.tick(800);
      chk("lowpower", st.lowpower, 1'b1);
      id_read(frp_pkg::OP_MFR_DEV, 0, 24, 1, 8, 4'h0, v);
      chk("lowpower held", st.lowpower, 1'b1);
      cmd(frp_pkg::OP_RELEASE, 1'b0, 0);
      chk("released", st.lowpower, 1'b0);
      i_host.tick(800);
      quad = 1'b1;
      cmd(frp_pkg::OP_LOWPOWER, 1'b1, 0);
      i_host.tick(800);
      chk("quad lowpower", st.lowpower, 1'b1);
      cmd(frp_pkg::OP_RELEASE, 1'b1, 6);
      chk("quad released", st.lowpower, 1'b0);
      quad = 1'b0;
      end_of_test();
   end
endmodule
